// >>> logic/asfr_pkg.sv
package asfr_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ASFR_OFS_FEEDBACK = 8'h04;
	localparam logic [7:0] ASFR_OFS_SLOT_MASK = 8'h30;
	localparam logic [7:0] ASFR_OFS_EVENTS = 8'h34;

	// ----------------------------------------
	// Slot 9/10 channel mask layout
	// ----------------------------------------
	localparam int ASFR_MASK_W = 4;
	localparam int ASFR_SLOT9_LSB = 0;
	localparam int ASFR_SLOT10_LSB = 4;
	localparam int ASFR_SLOT_USED_W = 8;
	localparam logic [7:0] ASFR_SLOT_MASK_RST = 8'h7B;

	// ----------------------------------------
	// Feedback register layout
	// ----------------------------------------
	localparam int ASFR_FB_SEQ_LSB = 0;
	localparam int ASFR_FB_HALT_BIT = 8;
	localparam int ASFR_FB_EIM_BIT = 9;
	localparam int ASFR_FB_ESM_BIT = 10;
	localparam int ASFR_FB_SQR_LSB = 11;
	localparam int ASFR_FB_CHAN_LSB = 16;

	// ----------------------------------------
	// Code ranges
	// ----------------------------------------
	localparam logic [4:0] ASFR_CHAN_LOW_LAST = 5'h06;
	localparam logic [4:0] ASFR_CHAN_HIGH_FIRST = 5'h1D;
	localparam logic [3:0] ASFR_SQR_LAST = 4'h9;
	localparam logic [2:0] ASFR_RESET_TYPE_FULL = 3'h4;

	// Current sequence codes
	typedef enum logic [3:0] {
		ASFR_SEQ_FIRST = 4'h0,
		ASFR_SEQ_LAST = 4'h9,
		ASFR_SEQ_EXC = 4'hA,
		ASFR_SEQ_EMPTY = 4'hB,
		ASFR_SEQ_SUSPEND = 4'hC
	} asfr_seq_code_t;

	// ----------------------------------------
	// Event register bit positions
	// ----------------------------------------
	localparam int ASFR_EV_BAD_CHAN = 0;
	localparam int ASFR_EV_BAD_SQR = 1;
	localparam int ASFR_EV_BAD_SEQ = 2;
	localparam int ASFR_EV_ESM_START = 3;
	localparam int ASFR_EV_EIM_START = 4;
	localparam int ASFR_EV_HALT = 5;
	localparam int ASFR_EV_WR_REFUSED = 6;
	localparam int ASFR_EV_W = 7;
	localparam logic [6:0] ASFR_EVENTS_RST = 7'h00;

	// Word address match on an aligned 32-bit register
	function automatic logic asfr_hit(input logic [7:0] adr, input logic [7:0] ofs);
		return adr[7:2] == ofs[7:2];
	endfunction

	// Channel code legality: 0..6 and 7..9 coded high
	function automatic logic asfr_chan_ok(input logic [4:0] code);
		return (code <= ASFR_CHAN_LOW_LAST) || (code >= ASFR_CHAN_HIGH_FIRST);
	endfunction

endpackage

// >>> logic/asfr_wb_slave.sv
`timescale 1ns/1ps
module asfr_wb_slave
	import asfr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone request
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	// Read word from the register file
	input wire logic [31:0] rd_word_i,
	// Wishbone answer
	output logic ack_o,
	output logic [31:0] dat_o,
	// Write commit strobe, one cycle, same edge the master sees ack
	output logic wr_fire_o
);

	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;

	// ----------------------------------------
	// Ack one cycle after the request, drop after
	// ----------------------------------------
	// Registered ack costs a cycle but keeps the read path off the bus
	always_comb begin
		ack_nxt = cyc_i & stb_i & ~ack_r;
		dat_nxt = dat_r;
		if (ack_nxt) begin
			dat_nxt = rd_word_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;
	// Write lands on the edge where the master samples ack
	assign wr_fire_o = ack_r & cyc_i & stb_i & we_i;

endmodule

// >>> logic/asfr_fb_capture.sv
`timescale 1ns/1ps
module asfr_fb_capture
	import asfr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Live sequencer state
	input wire logic [4:0] current_channel_i,
	input wire logic [3:0] current_sequencer_i,
	input wire logic [3:0] current_sequence_i,
	input wire logic exc_sequence_running_i,
	input wire logic exc_interrupt_meas_running_i,
	input wire logic postproc_halt_flag_i,
	// Snapshot and events
	output logic [31:0] fb_word_o,
	output logic [ASFR_EV_HALT:0] ev_o
);

	logic [4:0] chan_r, chan_nxt;
	logic [3:0] sqr_r, sqr_nxt;
	asfr_seq_code_t seq_r, seq_nxt;
	logic esm_r, esm_nxt;
	logic eim_r, eim_nxt;
	logic halt_r, halt_nxt;

	// ----------------------------------------
	// Snapshot of the sequencer state
	// ----------------------------------------
	always_comb begin
		chan_nxt = current_channel_i;
		sqr_nxt = current_sequencer_i;
		seq_nxt = asfr_seq_code_t'(current_sequence_i);
		esm_nxt = exc_sequence_running_i;
		eim_nxt = exc_interrupt_meas_running_i;
		halt_nxt = postproc_halt_flag_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_r <= 5'h00;
			sqr_r <= 4'h0;
			seq_r <= ASFR_SEQ_FIRST;
			esm_r <= 1'b0;
			eim_r <= 1'b0;
			halt_r <= 1'b0;
		end else begin
			chan_r <= chan_nxt;
			sqr_r <= sqr_nxt;
			seq_r <= seq_nxt;
			esm_r <= esm_nxt;
			eim_r <= eim_nxt;
			halt_r <= halt_nxt;
		end
	end

	// ----------------------------------------
	// Feedback word, reserved bits zero
	// ----------------------------------------
	always_comb begin
		fb_word_o = 32'h00000000;
		fb_word_o[ASFR_FB_CHAN_LSB +: 5] = chan_r;
		fb_word_o[ASFR_FB_SQR_LSB +: 4] = sqr_r;
		fb_word_o[ASFR_FB_ESM_BIT] = esm_r;
		fb_word_o[ASFR_FB_EIM_BIT] = eim_r;
		fb_word_o[ASFR_FB_HALT_BIT] = halt_r;
		fb_word_o[ASFR_FB_SEQ_LSB +: 4] = seq_r;
	end

	// Events: illegal codes and rising edges of the activity flags
	always_comb begin
		ev_o = '0;
		ev_o[ASFR_EV_BAD_CHAN] = ~asfr_chan_ok(chan_r);
		ev_o[ASFR_EV_BAD_SQR] = sqr_r > ASFR_SQR_LAST;
		ev_o[ASFR_EV_BAD_SEQ] = seq_r > ASFR_SEQ_SUSPEND;
		ev_o[ASFR_EV_ESM_START] = esm_nxt & ~esm_r;
		ev_o[ASFR_EV_EIM_START] = eim_nxt & ~eim_r;
		ev_o[ASFR_EV_HALT] = halt_nxt & ~halt_r;
	end

endmodule

// >>> logic/asfr_top.sv
// Contract
// - The slot 9/10 mask returns to its reset value only on the type-4 reset.
// - Bits 7:4 hold the sequence 10 mask, weights 1,2,4,8 for channels 6 to 9.
// - Bits 3:0 hold the sequence 9 mask, lowest bit for channel 6.
// - Bits 31:8 of the slot mask register always read zero.
// - Feedback bits 20:16 show the channel being converted.
// - Feedback bits 14:11 show the active sequencer index 0 to 9.
// - Feedback bit 10 is high while an exceptional sequence measurement runs.
// - Feedback bit 9 is high while an interrupt-triggered measurement runs.
// - Feedback bit 8 mirrors the halt signal sent to the postprocessing stage.
// - Feedback bits 3:0 show the current sequence or its special codes.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module asfr_top
	import asfr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// System reset requests
	input wire logic sys_reset_req_i,
	input wire logic [2:0] sys_reset_type_i,
	// Device register protection
	input wire logic prot_unlock_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Sequencer state
	input wire logic [4:0] current_channel_i,
	input wire logic [3:0] current_sequencer_i,
	input wire logic [3:0] current_sequence_i,
	input wire logic exc_sequence_running_i,
	input wire logic exc_interrupt_meas_running_i,
	input wire logic postproc_halt_flag_i,
	// Channel selection toward the sequencer
	output logic [ASFR_MASK_W-1:0] slot9_mask_o,
	output logic [ASFR_MASK_W-1:0] slot10_mask_o,
	output logic slot9_empty_o,
	output logic slot10_empty_o
);

	// Register targets of one bus access
	typedef enum logic [1:0] {
		ASFR_TGT_NONE = 2'b00,
		ASFR_TGT_FB = 2'b01,
		ASFR_TGT_MASK = 2'b10,
		ASFR_TGT_EVENTS = 2'b11
	} asfr_tgt_t;

	// Slot mask state, one register per sequence slot
	logic [ASFR_MASK_W-1:0] slot9_r;
	logic [ASFR_MASK_W-1:0] slot9_nxt;
	logic [ASFR_MASK_W-1:0] slot10_r;
	logic [ASFR_MASK_W-1:0] slot10_nxt;
	logic [ASFR_SLOT_USED_W-1:0] mask_word;
	// Empty-set flags, registered beside the masks
	logic slot9_empty_r;
	logic slot9_empty_nxt;
	logic slot10_empty_r;
	logic slot10_empty_nxt;
	// Sticky events
	logic [ASFR_EV_W-1:0] events_r;
	logic [ASFR_EV_W-1:0] events_nxt;
	logic [ASFR_EV_W-1:0] ev_set;
	logic [ASFR_EV_W-1:0] ev_clr;
	// Sequencer snapshot
	logic [31:0] fb_word;
	logic [ASFR_EV_HALT:0] fb_ev;
	// Bus side
	asfr_tgt_t tgt;
	logic [31:0] rd_word;
	logic wr_fire;
	logic hit_mask;
	logic hit_events;
	// Write and reset qualifiers
	logic full_reset;
	logic lane0_wr;
	logic mask_wr;
	logic mask_refused;
	logic events_wr;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// One slot's four channel bits out of the packed mask byte
	function automatic logic [ASFR_MASK_W-1:0] slot_field(
		input logic [ASFR_SLOT_USED_W-1:0] word,
		input int lsb
	);
		return word[lsb +: ASFR_MASK_W];
	endfunction

	// No channel selected: the sequencer then reports its empty-set code
	function automatic logic no_channel(input logic [ASFR_MASK_W-1:0] field);
		return ~|field;
	endfunction

	// Clear what software asked, then let fresh events win
	function automatic logic [ASFR_EV_W-1:0] w1c_merge(
		input logic [ASFR_EV_W-1:0] cur,
		input logic [ASFR_EV_W-1:0] clr,
		input logic [ASFR_EV_W-1:0] set
	);
		return (cur & ~clr) | set;
	endfunction

	// One target per access; the offsets never overlap
	function automatic asfr_tgt_t target_of(input logic [7:0] adr);
		if (asfr_hit(adr, ASFR_OFS_FEEDBACK)) begin
			return ASFR_TGT_FB;
		end else if (asfr_hit(adr, ASFR_OFS_SLOT_MASK)) begin
			return ASFR_TGT_MASK;
		end else if (asfr_hit(adr, ASFR_OFS_EVENTS)) begin
			return ASFR_TGT_EVENTS;
		end else begin
			return ASFR_TGT_NONE;
		end
	endfunction

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	asfr_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.rd_word_i(rd_word),
		.ack_o(ack_o),
		.dat_o(dat_o),
		.wr_fire_o(wr_fire)
	);

	// ----------------------------------------
	// Sequencer snapshot
	// ----------------------------------------
	asfr_fb_capture u_fb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.current_channel_i(current_channel_i),
		.current_sequencer_i(current_sequencer_i),
		.current_sequence_i(current_sequence_i),
		.exc_sequence_running_i(exc_sequence_running_i),
		.exc_interrupt_meas_running_i(exc_interrupt_meas_running_i),
		.postproc_halt_flag_i(postproc_halt_flag_i),
		.fb_word_o(fb_word),
		.ev_o(fb_ev)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Address match only; bits 1:0 of the byte address are ignored
	always_comb begin
		tgt = target_of(adr_i);
		hit_mask = (tgt == ASFR_TGT_MASK);
		hit_events = (tgt == ASFR_TGT_EVENTS);
	end

	// Write qualifiers taken on the edge at which the master sees ack; full_reset on any edge with a type-4 request
	always_comb begin
		full_reset = sys_reset_req_i && (sys_reset_type_i == ASFR_RESET_TYPE_FULL);
		// Only byte lane 0 carries defined bits
		lane0_wr = wr_fire & sel_i[0];
		// Protection locked means the write is dropped and raises the refused-write event
		mask_wr = lane0_wr & hit_mask & prot_unlock_i;
		mask_refused = lane0_wr & hit_mask & ~prot_unlock_i;
		events_wr = lane0_wr & hit_events;
	end

	// ----------------------------------------
	// Slot 9 channel set
	// ----------------------------------------
	// Lesser reset types leave the set alone so a warm restart keeps setup
	always_comb begin
		slot9_nxt = slot9_r;
		if (full_reset) begin
			slot9_nxt = slot_field(ASFR_SLOT_MASK_RST, ASFR_SLOT9_LSB);
		end else if (mask_wr) begin
			slot9_nxt = slot_field(dat_i[ASFR_SLOT_USED_W-1:0], ASFR_SLOT9_LSB);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot9_r <= slot_field(ASFR_SLOT_MASK_RST, ASFR_SLOT9_LSB);
		end else begin
			slot9_r <= slot9_nxt;
		end
	end

	// ----------------------------------------
	// Slot 10 channel set
	// ----------------------------------------
	// Same reset policy as slot 9; both halves share one write strobe
	always_comb begin
		slot10_nxt = slot10_r;
		if (full_reset) begin
			slot10_nxt = slot_field(ASFR_SLOT_MASK_RST, ASFR_SLOT10_LSB);
		end else if (mask_wr) begin
			slot10_nxt = slot_field(dat_i[ASFR_SLOT_USED_W-1:0], ASFR_SLOT10_LSB);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot10_r <= slot_field(ASFR_SLOT_MASK_RST, ASFR_SLOT10_LSB);
		end else begin
			slot10_r <= slot10_nxt;
		end
	end

	// ----------------------------------------
	// Packed mask and empty flags
	// ----------------------------------------
	// Packed view for the read path
	always_comb begin
		mask_word = '0;
		mask_word[ASFR_SLOT9_LSB +: ASFR_MASK_W] = slot9_r;
		mask_word[ASFR_SLOT10_LSB +: ASFR_MASK_W] = slot10_r;
	end

	// Flags follow the next masks so they change on the same edge as them
	always_comb begin
		slot9_empty_nxt = no_channel(slot9_nxt);
		slot10_empty_nxt = no_channel(slot10_nxt);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot9_empty_r <= no_channel(slot_field(ASFR_SLOT_MASK_RST, ASFR_SLOT9_LSB));
			slot10_empty_r <= no_channel(slot_field(ASFR_SLOT_MASK_RST, ASFR_SLOT10_LSB));
		end else begin
			slot9_empty_r <= slot9_empty_nxt;
			slot10_empty_r <= slot10_empty_nxt;
		end
	end

	// ----------------------------------------
	// Sticky events, write one to clear
	// ----------------------------------------
	// Sources: snapshot events and refused mask writes
	always_comb begin
		ev_set = '0;
		ev_set[ASFR_EV_HALT:0] = fb_ev;
		ev_set[ASFR_EV_WR_REFUSED] = mask_refused;
	end

	// Clears: ones written by software, or any system reset request
	always_comb begin
		ev_clr = '0;
		if (events_wr) begin
			ev_clr = dat_i[ASFR_EV_W-1:0];
		end
		if (sys_reset_req_i) begin
			ev_clr = '1;
		end
	end

	// A new event in the clearing cycle survives the clear
	always_comb begin
		events_nxt = w1c_merge(events_r, ev_clr, ev_set);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			events_r <= ASFR_EVENTS_RST;
		end else begin
			events_r <= events_nxt;
		end
	end

	// ----------------------------------------
	// Read mux, unmapped reads as zero
	// ----------------------------------------
	always_comb begin
		rd_word = 32'h00000000;
		unique case (tgt)
			ASFR_TGT_FB: begin
				rd_word = fb_word;
			end
			ASFR_TGT_MASK: begin
				rd_word[ASFR_SLOT_USED_W-1:0] = mask_word;
			end
			ASFR_TGT_EVENTS: begin
				rd_word[ASFR_EV_W-1:0] = events_r;
			end
			ASFR_TGT_NONE: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	// ----------------------------------------
	// Channel selection outputs
	// ----------------------------------------
	assign slot9_mask_o = slot9_r;
	assign slot10_mask_o = slot10_r;
	// Registered empty flags, no decode glitch toward the sequencer
	assign slot9_empty_o = slot9_empty_r;
	assign slot10_empty_o = slot10_empty_r;

endmodule

// >>> testbench/asfr_top_properties.sv
`timescale 1ns/1ps
module asfr_top_properties
	import asfr_pkg::*;
(
	// Clock, reset and controls
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sys_reset_req_i,
	input wire logic [2:0] sys_reset_type_i,
	input wire logic prot_unlock_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Sequencer side
	input wire logic [4:0] current_channel_i,
	input wire logic [3:0] current_sequencer_i,
	input wire logic [3:0] current_sequence_i,
	input wire logic exc_sequence_running_i,
	input wire logic exc_interrupt_meas_running_i,
	input wire logic postproc_halt_flag_i,
	input wire logic [ASFR_MASK_W-1:0] slot9_mask_o,
	input wire logic [ASFR_MASK_W-1:0] slot10_mask_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// --------------------
	// Bus cycle shapes
	// --------------------
	wire logic req = cyc_i && stb_i && !ack_o;
	sequence s_rd(w);
		req && !we_i && adr_i[7:2] == w ##1 ack_o;
	endsequence
	sequence s_wr;
		req && we_i && adr_i[7:2] == 6'h0C && sel_i[0] ##1 ack_o;
	endsequence
	AST_ACK_NEXT: assert property (req |=> ack_o) else $error("ack late");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	AST_MASK_HI: assert property (s_rd(6'h0C) |-> dat_o[31:8] == 24'h0)
		else $error("mask upper bits set");
	AST_RST4: assert property (sys_reset_req_i && sys_reset_type_i == 3'h4
		|=> {slot10_mask_o, slot9_mask_o} == 8'h7B) else $error("mask not reset");
	AST_RST_OTHER: assert property (sys_reset_req_i && sys_reset_type_i != 3'h4 && !ack_o
		|=> $stable({slot10_mask_o, slot9_mask_o})) else $error("mask lost on minor reset");
	AST_WR: assert property (s_wr ##0 prot_unlock_i
		|=> {slot10_mask_o, slot9_mask_o} == $past(dat_i[7:0])) else $error("mask write");
	AST_PROT: assert property (s_wr ##0 !prot_unlock_i && !sys_reset_req_i
		|=> $stable({slot10_mask_o, slot9_mask_o})) else $error("locked write taken");
	AST_FB_CHAN: assert property (s_rd(6'h01) |-> dat_o[21:16] == {1'b0, $past(current_channel_i, 2)})
		else $error("channel field");
	AST_FB_SQR: assert property (s_rd(6'h01) |-> dat_o[15:11] == {1'b0, $past(current_sequencer_i, 2)})
		else $error("sequencer field");
	AST_FB_FLAGS: assert property (s_rd(6'h01) |-> dat_o[10:8] == {$past(exc_sequence_running_i, 2),
		$past(exc_interrupt_meas_running_i, 2), $past(postproc_halt_flag_i, 2)}) else $error("flags");
	AST_FB_SEQ: assert property (s_rd(6'h01) |-> dat_o[7:0] == {4'h0, $past(current_sequence_i, 2)})
		else $error("sequence field");
endmodule
bind asfr_top asfr_top_properties i_chk (.*);

// >>> testbench/asfr_seq_model.sv
`timescale 1ns/1ps
module asfr_seq_model (
	// Clock
	input wire logic clk_i,
	// Live sequencer state
	output logic [4:0] current_channel_o,
	output logic [3:0] current_sequencer_o,
	output logic [3:0] current_sequence_o,
	output logic [2:0] flags_o
);
	// Idle sequencer until the bench moves it
	initial begin
		{current_channel_o, current_sequencer_o, current_sequence_o, flags_o} = '0;
	end
	// New state lands just after an edge, like the real sequencer
	task automatic step(input logic [4:0] ch, input logic [3:0] sq, input logic [3:0] sn,
		input logic [2:0] fl);
		@(posedge clk_i);
		{current_channel_o, current_sequencer_o, current_sequence_o, flags_o} <= {ch, sq, sn, fl};
	endtask
endmodule

// >>> testbench/asfr_top_tb.sv
`timescale 1ns/1ps
module asfr_top_tb;
	logic clk_i = 0;
	logic rst_i = 1;
	logic sys_reset_req_i = 0;
	logic [2:0] sys_reset_type_i = 0;
	logic prot_unlock_i = 1;
	logic cyc_i = 0;
	logic stb_i = 0;
	logic we_i = 0;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 0;
	logic [31:0] dat_o, rd;
	logic ack_o, slot9_empty_o, slot10_empty_o;
	logic [4:0] current_channel_i;
	logic [3:0] current_sequencer_i, current_sequence_i, slot9_mask_o, slot10_mask_o;
	logic exc_sequence_running_i, exc_interrupt_meas_running_i, postproc_halt_flag_i;
	logic [2:0] seq_flags;
	logic [4:0] chan_codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h1D, 5'h1E, 5'h1F};
	int failures = 0;
	int num_checks = 0;
	always #50 clk_i = ~clk_i;
	asfr_top i_dut (.*);
	asfr_seq_model i_seq (.clk_i(clk_i), .current_channel_o(current_channel_i),
		.current_sequencer_o(current_sequencer_i), .current_sequence_o(current_sequence_i),
		.flags_o(seq_flags));
	assign {exc_sequence_running_i, exc_interrupt_meas_running_i, postproc_halt_flag_i} = seq_flags;
	// --------------------
	// Shared bus cycle and compare
	// --------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
		rd = dat_o;
		if (n >= 20) begin
			failures++;
			$display("MISMATCH ack expected 1 seen 0");
		end
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic t_reset_values;
		wb(0, 8'h30, 0);
		chk("mask", 32'h7B, rd);
		wb(0, 8'h10, 0);
		chk("unmapped", 32'h0, rd);
		$display("reset_values done");
	endtask
	// One-hot weights in both slots, then an empty set
	task automatic t_mask_fields;
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			d = (i < 4) ? (8'h11 << i) : 8'h00;
			wb(1, 8'h30, {24'hFFFFFF, d});
			chk("slot9", d[3:0], slot9_mask_o);
			chk("slot10", d[7:4], slot10_mask_o);
			chk("empty", {d == 0, d == 0}, {slot10_empty_o, slot9_empty_o});
			wb(0, 8'h30, 0);
			chk("readback", {24'h0, d}, rd);
		end
		$display("mask_fields done");
	endtask
	task automatic t_protection;
		prot_unlock_i <= 0;
		wb(1, 8'h30, 32'h5A);
		wb(0, 8'h30, 0);
		chk("locked", 32'h0, rd);
		wb(0, 8'h34, 0);
		chk("refused_event", 32'h1 << asfr_pkg::ASFR_EV_WR_REFUSED, rd);
		wb(1, 8'h34, 32'h1 << asfr_pkg::ASFR_EV_WR_REFUSED);
		wb(0, 8'h34, 0);
		chk("event_clear", 32'h0, rd);
		prot_unlock_i <= 1;
		$display("protection done");
	endtask
	// Every reset type; only type 4 may restore the mask
	task automatic t_sys_reset;
		for (int t = 0; t < 8; t++) begin
			wb(1, 8'h30, 32'hC3);
			{sys_reset_req_i, sys_reset_type_i} <= {1'b1, 3'(t)};
			@(posedge clk_i);
			sys_reset_req_i <= 0;
			@(posedge clk_i);
			wb(0, 8'h30, 0);
			chk("sys_reset", (t == 4) ? 32'h7B : 32'hC3, rd);
		end
		$display("sys_reset done");
	endtask
	task automatic t_feedback;
		for (int i = 0; i < 13; i++) begin
			i_seq.step(chan_codes[i % 10], 4'(i % 10), 4'(i), 3'(i));
			repeat (2) @(posedge clk_i);
			wb(0, 8'h04, 0);
			chk("feedback", {11'h0, chan_codes[i % 10], 1'b0, 4'(i % 10), 3'(i), 4'h0, 4'(i)}, rd);
		end
		$display("feedback done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_reset_values;
		t_mask_fields;
		t_protection;
		t_sys_reset;
		t_feedback;
		test_done;
	end
	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#200000;
		failures++;
		test_done;
	end
endmodule
